// >>> vst_gen.sv
// Purpose: Raster sync and blanking timing generator for a display processor.
// Assumes: clk is the pixel input clock; slave sync inputs come from pins.
// Notes:   Pixel fetch, windows and memory are outside this block.
`timescale 1ns/1ps
module vst_gen
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        stage_wr,
  input  wire logic [2:0]  stage_sel,
  input  wire logic [11:0] stage_data,
  input  wire logic        cfg_stage_wr,
  input  wire logic [7:0]  cfg_stage_data,
  input  wire logic        load_every_register_cmd,
  input  wire logic        refresh_enable_bit,
  input  wire logic [7:0]  default_pixel,
  input  wire logic        ext_line_sync_in,
  input  wire logic        ext_frame_sync_in,
  input  wire logic        ext_blank_in,
  output logic             line_sync_out,
  output logic             line_sync_oe,
  output logic             frame_sync_out,
  output logic             frame_sync_oe,
  output logic             blank_out,
  output logic             blank_oe,
  output logic [7:0]       pixel_output_bus,
  output logic [3:0]       effective_pixel_rate,
  output logic             odd_field,
  output logic             line_pair_repeat,
  output logic             fetch_request
);
  vst_tim_if tim (); // Live timing values.

  logic [7:0]  cfg_stage_q;  // Staged monitor configuration.
  logic [7:0]  cfg_q;        // Live monitor configuration register.
  logic        cfg_seen_q;   // Configuration has been loaded once.
  logic [11:0] hcnt_q;       // Pixel count in the line.
  logic [11:0] vcnt_q;       // Line count in the field.
  logic        field_q;      // High during the second field.
  logic        hs_q;         // Internally made line sync.
  logic        vs_q;         // Internally made frame sync.
  logic        bl_q;         // Internally made blanking.
  logic [1:0]  ls_s_q;       // Slave line sync synchroniser.
  logic [1:0]  fs_s_q;       // Slave frame sync synchroniser.
  logic [1:0]  bk_s_q;       // Slave blank synchroniser.
  logic [1:0]  ref_s_q;      // Refresh enable, passed through two flops before use.
  logic        line_wrap;    // Last pixel of the line.
  logic        field_wrap;   // Last line of the field.
  logic        slave;        // Slave video mode selected.
  logic        interl;       // Interlaced sync timing selected.
  logic [1:0]  acc;          // Acceleration code.
  logic [11:0] vsync_len;    // Effective frame sync end for this field.

  vst_bank u_bank
  (
    .clk        (clk),
    .reset_n    (reset_n),
    .stage_wr   (stage_wr),
    .stage_sel  (stage_sel),
    .stage_data (stage_data),
    .load_all   (load_every_register_cmd),
    .tim        (tim.src)
  );

  assign acc        = cfg_q[vst_pkg::CFG_ACC_HI:vst_pkg::CFG_ACC_LO];
  assign slave      = cfg_q[vst_pkg::CFG_SLV_A] & cfg_q[vst_pkg::CFG_SLV_B];
  assign interl     = (cfg_q[vst_pkg::CFG_ILC_HI:vst_pkg::CFG_ILC_LO] == 2'(vst_pkg::VST_INTERL))
                   || (cfg_q[vst_pkg::CFG_ILC_HI:vst_pkg::CFG_ILC_LO] == 2'(vst_pkg::VST_INT_SYNC));
  assign line_wrap  = (hcnt_q >= tim.line_total_count);
  assign field_wrap = (vcnt_q >= tim.frame_total_count);
  // The second interlaced field starts half a line late, so its sync ends one line later.
  assign vsync_len  = (interl && field_q) ? tim.frame_sync_end + vst_pkg::TIME_ONE
                                          : tim.frame_sync_end;

  // Configuration staging and the load that makes it live together with timing.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cfg_stage_q <= vst_pkg::CFG_RESET;
      cfg_q       <= vst_pkg::CFG_RESET;
      cfg_seen_q  <= 1'b0;
    end
    else
    begin
      if (cfg_stage_wr)
      begin
        cfg_stage_q <= cfg_stage_data;
      end
      if (load_every_register_cmd)
      begin
        cfg_q      <= cfg_stage_q;
        cfg_seen_q <= 1'b1;
      end
    end
  end

  // Horizontal counter; the compare uses >= so a shrunk line never runs away.
  always_ff @(posedge clk)
  begin
    if (!reset_n || line_wrap)
    begin
      hcnt_q <= vst_pkg::TIME_ZERO;
    end
    else
    begin
      hcnt_q <= hcnt_q + vst_pkg::TIME_ONE;
    end
  end

  // Vertical counter and field parity; total plus one lines per field.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      vcnt_q  <= vst_pkg::TIME_ZERO;
      field_q <= 1'b0;
    end
    else if (line_wrap)
    begin
      if (field_wrap)
      begin
        vcnt_q  <= vst_pkg::TIME_ZERO;
        field_q <= interl ? ~field_q : 1'b0;
      end
      else
      begin
        vcnt_q <= vcnt_q + vst_pkg::TIME_ONE;
      end
    end
  end

  // Internal sync and blank, registered so they follow the counts one clock behind.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      hs_q <= 1'b0;
      vs_q <= 1'b0;
      bl_q <= 1'b1;
    end
    else
    begin
      hs_q <= (hcnt_q <= tim.line_sync_end);
      vs_q <= (vcnt_q <= vsync_len);
      bl_q <= !((hcnt_q >= tim.line_active_begin) && (hcnt_q < tim.line_active_end)
             && (vcnt_q >= tim.frame_active_begin) && (vcnt_q < tim.frame_active_end));
    end
  end

  // Slave inputs come from pins, so each passes two flops first.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ls_s_q  <= 2'h0;
      fs_s_q  <= 2'h0;
      bk_s_q  <= 2'h3;
      ref_s_q <= 2'h0;
    end
    else
    begin
      ls_s_q  <= {ls_s_q[0], ext_line_sync_in};
      fs_s_q  <= {fs_s_q[0], ext_frame_sync_in};
      bk_s_q  <= {bk_s_q[0], ext_blank_in};
      ref_s_q <= {ref_s_q[0], refresh_enable_bit};
    end
  end

  // Pin drivers; enables stay low until the configuration is loaded once.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      line_sync_out  <= 1'b0;
      frame_sync_out <= 1'b0;
      blank_out      <= 1'b1;
      line_sync_oe   <= 1'b0;
      frame_sync_oe  <= 1'b0;
      blank_oe       <= 1'b0;
    end
    else
    begin
      line_sync_out  <= hs_q;
      frame_sync_out <= vs_q;
      blank_out      <= slave ? bk_s_q[1] : bl_q;
      line_sync_oe   <= cfg_seen_q && !slave;
      frame_sync_oe  <= cfg_seen_q && !slave;
      blank_oe       <= cfg_seen_q && !slave;
    end
  end

  // Pixel side status: rate factor, field parity, pair repeat, fetch request.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pixel_output_bus     <= vst_pkg::PIX_DEFAULT;
      effective_pixel_rate <= 4'h1;
      odd_field            <= 1'b0;
      line_pair_repeat     <= 1'b0;
      fetch_request        <= 1'b0;
    end
    else
    begin
      pixel_output_bus     <= default_pixel;
      effective_pixel_rate <= 4'h1 << acc;
      odd_field            <= slave ? fs_s_q[1] & ls_s_q[1] & 1'b0 : field_q;
      line_pair_repeat     <= (cfg_q[vst_pkg::CFG_ILC_HI:vst_pkg::CFG_ILC_LO]
                               == 2'(vst_pkg::VST_INT_SYNC));
      fetch_request        <= ref_s_q[1] && (slave ? !bk_s_q[1] : !bl_q);
    end
  end
endmodule

// >>> vst_pkg.sv
// Purpose: Shared constants and types for the video sync timing generator.
// Assumes: One 200 MHz clock; timing values are 12-bit counts.
// Notes:   Monitor configuration field positions and codes live here only.
package vst_pkg;
  localparam int unsigned TW          = 12;      // Width of every timing value.
  localparam logic [11:0] TIME_ZERO   = 12'h000; // Counter restart value.
  localparam logic [11:0] TIME_ONE    = 12'h001; // Counter step.
  // Monitor configuration register layout.
  localparam int unsigned CFG_W       = 8;       // Register width.
  localparam int unsigned CFG_ACC_LO  = 0;       // Acceleration field, low bit.
  localparam int unsigned CFG_ACC_HI  = 1;       // Acceleration field, high bit.
  localparam int unsigned CFG_SLV_A   = 2;       // Slave select, first bit.
  localparam int unsigned CFG_SLV_B   = 3;       // Slave select, second bit.
  localparam int unsigned CFG_ILC_LO  = 4;       // Interlace setting, low bit.
  localparam int unsigned CFG_ILC_HI  = 5;       // Interlace setting, high bit.
  localparam logic [7:0]  CFG_RESET   = 8'h00;   // All zero: internal, plain.
  localparam logic [7:0]  PIX_DEFAULT = 8'h00;   // Reset default pixel value.
  // Acceleration factors as shift amounts: 1, 2, 4, 8.
  localparam logic [1:0]  ACC_X1      = 2'h0;
  localparam logic [1:0]  ACC_X8      = 2'h3;

  // Interlace setting codes.
  typedef enum logic [1:0]
  {
    VST_NONINT   = 2'h0,
    VST_INTERL   = 2'h1,
    VST_INT_SYNC = 2'h2,
    VST_RSVD     = 2'h3
  } vst_ilc_t;
endpackage

// >>> vst_tim_if.sv
// Purpose: Carrier of the eight live timing values between the generator modules.
// Assumes: All values change together on one clock edge.
// Notes:   Driven by the shadow bank, read by the raster counters.
`timescale 1ns/1ps
interface vst_tim_if;
  logic [11:0] line_sync_end;      // Last line-sync pixel count.
  logic [11:0] line_active_begin;  // First active pixel count.
  logic [11:0] line_active_end;    // First blank pixel after active span.
  logic [11:0] line_total_count;   // Last pixel count of a line.
  logic [11:0] frame_sync_end;     // Last frame-sync line.
  logic [11:0] frame_active_begin; // First active line.
  logic [11:0] frame_active_end;   // First blank line after active span.
  logic [11:0] frame_total_count;  // Last line of a field.
  modport src (output line_sync_end, line_active_begin, line_active_end, line_total_count,
               output frame_sync_end, frame_active_begin, frame_active_end,
               output frame_total_count);
  modport dst (input line_sync_end, line_active_begin, line_active_end, line_total_count,
               input frame_sync_end, frame_active_begin, frame_active_end,
               input frame_total_count);
endinterface

// >>> vst_bank.sv
// Purpose: Staged and live copies of the eight timing values.
// Assumes: Staging writes and the load-all command come from the same clock.
// Notes:   Live values only change on the load-every-register command.
`timescale 1ns/1ps
module vst_bank
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        stage_wr,
  input  wire logic [2:0]  stage_sel,
  input  wire logic [11:0] stage_data,
  input  wire logic        load_all,
  vst_tim_if.src           tim
);
  logic [11:0] stage_q [8]; // Staged values, written one at a time.
  logic [11:0] live_q  [8]; // Values the counters use.

  // Staging writes are held back from the counters so a half-written set never shows.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 8; i++)
      begin
        stage_q[i] <= vst_pkg::TIME_ZERO;
      end
    end
    else if (stage_wr)
    begin
      stage_q[stage_sel] <= stage_data;
    end
  end

  // All eight move together; a write in the same cycle is caught the next load.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 8; i++)
      begin
        live_q[i] <= vst_pkg::TIME_ZERO;
      end
    end
    else if (load_all)
    begin
      live_q <= stage_q;
    end
  end

  assign tim.line_sync_end      = live_q[0];
  assign tim.line_active_begin  = live_q[1];
  assign tim.line_active_end    = live_q[2];
  assign tim.line_total_count   = live_q[3];
  assign tim.frame_sync_end     = live_q[4];
  assign tim.frame_active_begin = live_q[5];
  assign tim.frame_active_end   = live_q[6];
  assign tim.frame_total_count  = live_q[7];
endmodule

// >>> vst_gen_props.sv
// Purpose: Port-level assertions for the sync timing generator.
// Assumes: One clock; reset_n is synchronous and active low.
// Notes:   Bound to every vst_gen instance.
`timescale 1ns/1ps
module vst_gen_props
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       load_every_register_cmd,
  input wire logic       refresh_enable_bit,
  input wire logic [7:0] default_pixel,
  input wire logic       line_sync_out,
  input wire logic       line_sync_oe,
  input wire logic       frame_sync_out,
  input wire logic       frame_sync_oe,
  input wire logic       blank_out,
  input wire logic       blank_oe,
  input wire logic [7:0] pixel_output_bus,
  input wire logic [3:0] effective_pixel_rate,
  input wire logic       odd_field,
  input wire logic       fetch_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A change of pin drive is only allowed as the answer to a load.
  sequence s_loaded;
    $past(load_every_register_cmd, 2) || $past(load_every_register_cmd, 3);
  endsequence
  // Reset itself must float the pins, so this one is never disabled.
  a_oe_reset: assert property (disable iff (1'b0) !reset_n |=> !line_sync_oe && !blank_oe)
    else $error("pins driven after reset");
  a_blank_reset: assert property (disable iff (1'b0) !reset_n |=> blank_out)
    else $error("blank low after reset");
  a_oe_rise_load: assert property ($rose(line_sync_oe) |-> s_loaded)
    else $error("pins driven without a load");
  a_oe_fall_load: assert property ($fell(line_sync_oe) |-> s_loaded)
    else $error("pins released without a load");
  a_oe_pair: assert property (line_sync_oe == frame_sync_oe)
    else $error("sync enables differ");
  a_pixel_follow: assert property ($past(reset_n) |-> pixel_output_bus == $past(default_pixel))
    else $error("pixel bus not the default value");
  a_rate_factor: assert property ($onehot(effective_pixel_rate))
    else $error("pixel rate not a power of two");
  a_fetch_idle: assert property (!refresh_enable_bit [*5] |-> !fetch_request)
    else $error("fetch while refresh is off");
  a_frame_at_line: assert property (line_sync_oe && $rose(frame_sync_out) |-> $rose(line_sync_out))
    else $error("frame sync not at a line start");
  c_drive: cover property ($rose(line_sync_oe));
  c_field: cover property ($rose(odd_field));
  c_fetch: cover property ($rose(fetch_request));
endmodule
bind vst_gen vst_gen_props vst_gen_props_u (.clk, .reset_n, .load_every_register_cmd,
  .refresh_enable_bit, .default_pixel, .line_sync_out, .line_sync_oe, .frame_sync_out,
  .frame_sync_oe, .blank_out, .blank_oe, .pixel_output_bus, .effective_pixel_rate,
  .odd_field, .fetch_request);

// >>> vst_crt_model.sv
// Purpose: Raster monitor model that measures the sync and blank pins.
// Assumes: Pins sampled on the pixel clock.
// Notes:   An undriven pin shows a changing level, never the last value.
`timescale 1ns/1ps
module vst_crt_model
(
  input  wire logic   clk,
  input  wire logic   line_sync_out,
  input  wire logic   line_sync_oe,
  input  wire logic   frame_sync_out,
  input  wire logic   frame_sync_oe,
  input  wire logic   blank_out,
  input  wire logic   blank_oe,
  output logic        ext_line_sync_in,
  output logic        ext_frame_sync_in,
  output logic        ext_blank_in,
  output logic [11:0] hs_width,
  output logic [11:0] hs_period,
  output logic [11:0] vs_lines,
  output logic [11:0] field_lines,
  output logic [11:0] act_cycles
);
  logic        tog_q = 1'b0;                    // Level of a floating pin.
  logic        ls_q = 1'b0, fs_q = 1'b0;        // Pin levels one clock ago.
  logic [11:0] hw_q = 12'h000, hp_q = 12'h000;  // Sync width and period runs.
  logic [11:0] vl_q = 12'h000, fl_q = 12'h000;  // Sync lines and field lines.
  logic [11:0] ac_q = 12'h000;                  // Unblanked clocks this field.
  assign ext_line_sync_in  = line_sync_oe ? line_sync_out : tog_q;
  assign ext_frame_sync_in = frame_sync_oe ? frame_sync_out : tog_q;
  assign ext_blank_in      = blank_oe ? blank_out : ~tog_q;
  // Measurements are latched on edges of the pins, so a partial line is ignored.
  always_ff @(posedge clk)
  begin
    tog_q <= ~tog_q;
    ls_q  <= ext_line_sync_in;
    fs_q  <= ext_frame_sync_in;
    hw_q  <= ext_line_sync_in ? hw_q + 12'h001 : 12'h000;
    hp_q  <= hp_q + 12'h001;
    ac_q  <= ac_q + {11'h000, ~ext_blank_in};
    if (ls_q && !ext_line_sync_in)
      hs_width <= hw_q;
    if (fs_q && !ext_frame_sync_in)
      vs_lines <= vl_q;
    if (ext_line_sync_in && !ls_q)
    begin
      hs_period <= hp_q;
      hp_q      <= 12'h001;
      fl_q      <= fl_q + 12'h001;
      vl_q      <= vl_q + {11'h000, ext_frame_sync_in};
      if (ext_frame_sync_in && !fs_q)
      begin
        field_lines <= fl_q;
        act_cycles  <= ac_q;
        fl_q        <= 12'h001;
        vl_q        <= 12'h001;
        ac_q        <= 12'h000;
      end
    end
  end
endmodule

// >>> testbench.sv
// Purpose: Self-checking bench for the sync timing generator.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Small timing values keep a field near 100 clocks.
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0, reset_n = 1'b0, stage_wr = 1'b0, cfg_stage_wr = 1'b0;
  logic        load_every_register_cmd = 1'b0, refresh_enable_bit = 1'b0;
  logic [2:0]  stage_sel = 3'h0;
  logic [11:0] stage_data = 12'h000;
  logic [7:0]  cfg_stage_data = 8'h00, default_pixel = 8'hA5, pixel_output_bus;
  logic        ext_line_sync_in, ext_frame_sync_in, ext_blank_in, odd_field;
  logic        line_sync_out, line_sync_oe, frame_sync_out, frame_sync_oe;
  logic        blank_out, blank_oe, line_pair_repeat, fetch_request, o;
  logic [3:0]  effective_pixel_rate;
  logic [11:0] hs_width, hs_period, vs_lines, field_lines, act_cycles;
  // Ordered timing set; an active span of 8 suits every acceleration factor, and 7 lines
  // per field give the odd line count that an interlaced raster needs.
  logic [11:0] tv [8] = '{12'h001, 12'h003, 12'h00B, 12'h00D,
                          12'h001, 12'h002, 12'h004, 12'h006};
  int          bad_count = 0, check_count = 0, f, n;
  vst_gen dut_u (.clk, .reset_n, .stage_wr, .stage_sel, .stage_data, .cfg_stage_wr,
    .cfg_stage_data, .load_every_register_cmd, .refresh_enable_bit, .default_pixel,
    .ext_line_sync_in, .ext_frame_sync_in, .ext_blank_in, .line_sync_out, .line_sync_oe,
    .frame_sync_out, .frame_sync_oe, .blank_out, .blank_oe, .pixel_output_bus,
    .effective_pixel_rate, .odd_field, .line_pair_repeat, .fetch_request);
  vst_crt_model crt_u (.clk, .line_sync_out, .line_sync_oe, .frame_sync_out, .frame_sync_oe,
    .blank_out, .blank_oe, .ext_line_sync_in, .ext_frame_sync_in, .ext_blank_in, .hs_width,
    .hs_period, .vs_lines, .field_lines, .act_cycles);
  initial
    forever #2.5 clk = ~clk;
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // Strobe code: 4 stages a timing value, 2 stages the config, 1 loads all.
  task automatic put(input logic [2:0] k, input logic [2:0] s, input logic [11:0] v);
    {stage_wr, cfg_stage_wr, load_every_register_cmd} = k;
    stage_sel      = s;
    stage_data     = v;
    cfg_stage_data = v[7:0];
    tick(1);
    {stage_wr, cfg_stage_wr, load_every_register_cmd} = 3'h0;
    tick(1);
  endtask
  task automatic cfg_load(input logic [7:0] c);
    put(3'h2, 3'h0, {4'h0, c});
    put(3'h1, 3'h0, 12'h000);
    f = (tv[3] + 1) * (tv[7] + 1);
    tick(3 * f);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Guard against a hang; the tests need about 4000 clocks.
  initial
  begin
    #100000;
    bad_count++;
    wrap_up();
  end
  initial
  begin
    tick(12);
    reset_n = 1'b1;
    tick(1);
    for (int i = 0; i < 8; i++)
      put(3'h4, i[2:0], tv[i]);
    check({line_sync_oe, frame_sync_oe, blank_oe}, 3'h0);
    cfg_load(8'h00);
    check({line_sync_oe, frame_sync_oe, blank_oe}, 3'h7);
    check(hs_width, tv[0] + 1);
    check(hs_period, tv[3] + 1);
    check(vs_lines, tv[4] + 1);
    check(field_lines, tv[7] + 1);
    check(act_cycles, (tv[2] - tv[1]) * (tv[6] - tv[5]));
    check({odd_field, line_pair_repeat, fetch_request}, 3'h0);
    default_pixel = 8'h5A;
    tick(2);
    check(pixel_output_bus, 8'h5A);
    for (int a = 0; a < 4; a++)
    begin
      cfg_load(a[7:0]);
      check(effective_pixel_rate, 12'h001 << a);
    end
    put(3'h4, 3'h3, 12'h00F);
    tick(2 * f);
    check(hs_period, tv[3] + 1);
    tv[3] = 12'h00F;
    cfg_load(8'h03);
    check(hs_period, tv[3] + 1);
    check(field_lines, tv[7] + 1);
    for (int m = 1; m < 3; m++)
    begin
      cfg_load(8'(m << 4));
      o = odd_field;
      tick(f);
      check(odd_field, !o);
      check(line_pair_repeat, m == 2);
    end
    refresh_enable_bit = 1'b1;
    n = 0;
    while (fetch_request !== 1'b1 && n < 2 * f)
    begin
      tick(1);
      n++;
    end
    check(fetch_request, 1'b1);
    cfg_load(8'h0C);
    check({line_sync_oe, frame_sync_oe, blank_oe, odd_field}, 4'h0);
    cfg_load(8'h00);
    reset_n = 1'b0;
    tick(2);
    check({line_sync_oe, blank_out}, 2'h1);
    reset_n = 1'b1;
    tick(4);
    wrap_up();
  end
endmodule
